// File: logic/lcd_host_port.sv
// Parallel host port of a character LCD controller with write FIFO and busy flag.
// Contract
// - Select low: writes go to instruction register, reads return busy and counter.
// - Select high: reads and writes both use the data register.
// - Read/write high requests a read, low requests a write.
// - Strobe high starts access; falling edge captures write or ends read.
// - In 4-bit mode only upper four lanes carry data.
// - Busy indication is presented on the top data lane.
// - Shared lane three pin is latched as the I2C sub-address bit.
// - Power-down input high selects power-down; low for normal operation.
// - Oscillator pin tied high selects internal oscillator, else external clock.
// - Busy one rejects instructions; in 8-bit mode the counter appears on seven low lanes.
// - Instruction register is write-only to the host.
`timescale 1ns/10ps
`default_nettype none
module lcd_host_port #(
  parameter int BUSY_CYCLES = lcd_host_port_pkg::BUSY_CYCLES,
  parameter int FIFO_DEPTH  = lcd_host_port_pkg::FIFO_DEPTH
) (
  input  wire logic       CLK,
  input  wire logic       RESET,
  input  wire logic       STROBE,
  input  wire logic       REG_SELECT,
  input  wire logic       READ_NWRITE,
  input  wire logic [7:0] HOST_DATA_LANES_IN,
  output logic      [7:0] HOST_DATA_LANES_OUT,
  output logic            HOST_DATA_LANES_OE_N,
  input  wire logic       BUS_4BIT,
  input  wire logic       I2C_ACTIVE,
  input  wire logic       POWERDOWN_IN,
  input  wire logic       OSC_PIN_HIGH,
  input  wire logic [6:0] ADDR_COUNTER_IN,
  input  wire logic [7:0] READ_DATA_IN,
  input  wire logic       CORE_DONE,
  output logic      [7:0] CMD_DATA,
  output logic            CMD_IS_DATA,
  output logic            CMD_VALID,
  input  wire logic       CMD_READY,
  output logic            READ_DATA_POP,
  output logic            BUSY,
  output logic            I2C_SUBADDR_BIT,
  output logic            POWERDOWN,
  output logic            USE_INT_OSC
);
  // ****************************************
  // Declarations
  // ****************************************
  lcd_host_port_pkg::access_state_type state_reg;
  logic       strobe_dly_reg;
  logic       strobe_fall;
  logic       strobe_rise;
  logic       nibble_low_reg;
  logic [3:0] high_nibble_reg;
  logic [7:0] write_byte;
  logic       byte_done;
  logic       wr_valid_reg;
  logic [8:0] wr_word_reg;
  logic       fifo_in_ready;
  logic [8:0] fifo_out_data;
  logic       fifo_out_valid;
  logic       busy_reg;
  logic [$clog2(BUSY_CYCLES+1)-1:0] busy_cnt_reg;
  logic [7:0] read_word;
  logic       pd_reg;

  // Strobe edge detection.
  assign strobe_rise = STROBE && !strobe_dly_reg && !I2C_ACTIVE;
  assign strobe_fall = !STROBE && (state_reg == lcd_host_port_pkg::ST_ACCESS);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      strobe_dly_reg <= 1'b0;
    end else begin
      strobe_dly_reg <= STROBE && !I2C_ACTIVE;
    end
  end

  // Access state follows the strobe; power-down and serial mode abandon an open access.
  always_ff @(posedge CLK) begin
    if (RESET || pd_reg || I2C_ACTIVE) begin
      state_reg <= lcd_host_port_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        lcd_host_port_pkg::ST_IDLE: begin
          if (strobe_rise) begin
            state_reg <= lcd_host_port_pkg::ST_ACCESS;
          end
        end
        lcd_host_port_pkg::ST_ACCESS: begin
          if (!STROBE) begin
            state_reg <= lcd_host_port_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= lcd_host_port_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Status word when select is low, data register when high; instruction never read.
  assign read_word = REG_SELECT ? READ_DATA_IN
                                : {busy_reg, ADDR_COUNTER_IN};

  // Bus drive and nibble selection for reads.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      HOST_DATA_LANES_OUT  <= lcd_host_port_pkg::DATA_RESET;
      HOST_DATA_LANES_OE_N <= 1'b1;
    end else begin
      HOST_DATA_LANES_OE_N <= !(STROBE && READ_NWRITE && !I2C_ACTIVE && !pd_reg);
      if (!BUS_4BIT) begin
        HOST_DATA_LANES_OUT <= read_word;
      end else if (!nibble_low_reg) begin
        HOST_DATA_LANES_OUT <= {read_word[7:4], 4'h0};
      end else begin
        HOST_DATA_LANES_OUT <= {read_word[3:0], 4'h0};
      end
    end
  end

  // Data register read advances the core after the full byte.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      READ_DATA_POP <= 1'b0;
    end else begin
      READ_DATA_POP <= strobe_fall && READ_NWRITE && REG_SELECT &&
                       (!BUS_4BIT || nibble_low_reg);
    end
  end

  // ****************************************
  // Write path
  // ****************************************
  // Nibble phase toggles on each falling strobe in 4-bit mode.
  always_ff @(posedge CLK) begin
    if (RESET || !BUS_4BIT || pd_reg) begin
      nibble_low_reg  <= 1'b0;
      high_nibble_reg <= 4'h0;
    end else if (strobe_fall) begin
      nibble_low_reg <= !nibble_low_reg;
      if (!nibble_low_reg) begin
        high_nibble_reg <= HOST_DATA_LANES_IN[7:4];
      end
    end
  end

  assign write_byte = BUS_4BIT ? {high_nibble_reg, HOST_DATA_LANES_IN[7:4]}
                               : HOST_DATA_LANES_IN;
  assign byte_done  = strobe_fall && !READ_NWRITE &&
                      (!BUS_4BIT || nibble_low_reg);

  // Capture a finished write; instructions are dropped while busy.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      wr_valid_reg <= 1'b0;
      wr_word_reg  <= 9'h000;
    end else begin
      wr_valid_reg <= byte_done && !pd_reg && (REG_SELECT || !busy_reg);
      if (byte_done) begin
        wr_word_reg <= {REG_SELECT, write_byte};
      end
    end
  end

  lcd_fifo #(
    .WIDTH (lcd_host_port_pkg::DATA_WIDTH + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .CLK       (CLK),
    .RESET     (RESET || pd_reg),
    .in_data   (wr_word_reg),
    .in_valid  (wr_valid_reg),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (CMD_READY && !CMD_VALID)
  );

  // Output stage of the command stream toward the core.
  always_ff @(posedge CLK) begin
    if (RESET || pd_reg) begin
      CMD_VALID   <= 1'b0;
      CMD_DATA    <= lcd_host_port_pkg::DATA_RESET;
      CMD_IS_DATA <= 1'b0;
    end else if (CMD_VALID && CMD_READY) begin
      CMD_VALID <= 1'b0;
    end else if (fifo_out_valid && CMD_READY && !CMD_VALID) begin
      CMD_VALID   <= 1'b1;
      CMD_DATA    <= fifo_out_data[7:0];
      CMD_IS_DATA <= fifo_out_data[8];
    end
  end

  // ****************************************
  // Busy flag
  // ****************************************
  // Busy rises on any accepted write or full FIFO; clears on core done or timeout once no command is queued.
  always_ff @(posedge CLK) begin
    if (RESET || pd_reg) begin
      busy_reg     <= 1'b0;
      busy_cnt_reg <= '0;
    end else if (wr_valid_reg || !fifo_in_ready) begin
      busy_reg     <= 1'b1;
      busy_cnt_reg <= ($clog2(BUSY_CYCLES+1))'(BUSY_CYCLES);
    end else if (busy_reg && (CORE_DONE || busy_cnt_reg <= 1)) begin
      busy_reg     <= fifo_out_valid || CMD_VALID;
      busy_cnt_reg <= '0;
    end else if (busy_cnt_reg != 0) begin
      busy_cnt_reg <= busy_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      BUSY <= 1'b0;
    end else begin
      BUSY <= busy_reg;
    end
  end

  // ****************************************
  // Straps and mode pins
  // ****************************************
  // Sub-address caught from lane three while serial mode is active.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      I2C_SUBADDR_BIT <= 1'b0;
    end else if (I2C_ACTIVE) begin
      I2C_SUBADDR_BIT <= HOST_DATA_LANES_IN[lcd_host_port_pkg::SUBADDR_LANE];
    end
  end

  // Power-down and oscillator selection.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pd_reg      <= 1'b0;
      POWERDOWN   <= 1'b0;
      USE_INT_OSC <= 1'b1;
    end else begin
      pd_reg      <= POWERDOWN_IN;
      POWERDOWN   <= POWERDOWN_IN;
      USE_INT_OSC <= OSC_PIN_HIGH;
    end
  end
endmodule : lcd_host_port
`default_nettype wire

// File: logic/lcd_host_port_pkg.sv
// Package of constants shared by the LCD host port and its FIFO.
`default_nettype none
package lcd_host_port_pkg;
  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int          DATA_WIDTH     = 8;
  localparam int          NIBBLE_WIDTH   = 4;
  localparam int          FIFO_DEPTH     = 8;
  localparam int          ADDR_WIDTH     = 7;
  localparam logic [7:0]  DATA_RESET     = 8'h00;
  localparam logic [6:0]  ADDR_RESET     = 7'h00;
  localparam int          BUSY_LANE      = 7;
  localparam int          SUBADDR_LANE   = 3;
  // ****************************************
  // Timing
  // ****************************************
  localparam int          CLK_PERIOD_NS  = 50;
  localparam int          BUSY_TIME_NS   = 2000;
  localparam int          BUSY_CYCLES    = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************
  // Access state machine
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ACCESS = 2'b01
  } access_state_type;
endpackage : lcd_host_port_pkg
`default_nettype wire

// File: logic/lcd_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module lcd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             CLK,
  input  wire logic             RESET,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW:0]      wr_ptr_reg;
  logic [PW:0]      rd_ptr_reg;
  logic             do_push;
  logic             do_pop;
  logic [WIDTH-1:0] out_data_reg;
  logic [PW:0]      rd_ptr_next;

  // Full when pointers differ only in the wrap bit, empty when equal.
  assign in_ready  = !((wr_ptr_reg[PW] != rd_ptr_reg[PW]) &&
                       (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]));
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;
  assign rd_ptr_next = rd_ptr_reg + {{PW{1'b0}}, do_pop};
  assign out_data    = out_data_reg;

  // Head word is held in a register; a push into the slot about to be read bypasses storage.
  always_ff @(posedge CLK) begin
    if (do_push && (wr_ptr_reg[PW-1:0] == rd_ptr_next[PW-1:0])) begin
      out_data_reg <= in_data;
    end else begin
      out_data_reg <= mem_reg[rd_ptr_next[PW-1:0]];
    end
  end

  // Storage write.
  always_ff @(posedge CLK) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg[PW-1:0]] <= in_data;
    end
  end

  // Pointer update.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule : lcd_fifo
`default_nettype wire

// File: sim/lcd_host_port_assertions.sv
// Checker that watches the LCD host port pins, and its bind.
`timescale 1ns/10ps
`default_nettype none
module lcd_host_port_checker (
  input wire logic       CLK,
  input wire logic       RESET,
  input wire logic       STROBE,
  input wire logic       READ_NWRITE,
  input wire logic       I2C_ACTIVE,
  input wire logic       OSC_PIN_HIGH,
  input wire logic       POWERDOWN_IN,
  input wire logic [7:0] HOST_DATA_LANES_IN,
  input wire logic       HOST_DATA_LANES_OE_N,
  input wire logic [7:0] CMD_DATA,
  input wire logic       CMD_VALID,
  input wire logic       CMD_READY,
  input wire logic       BUSY,
  input wire logic       I2C_SUBADDR_BIT,
  input wire logic       POWERDOWN,
  input wire logic       USE_INT_OSC
);
  // Every relation is sampled on the rising clock and is void during reset.
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  a_oe_read_only: assert property (!HOST_DATA_LANES_OE_N |-> $past(STROBE && READ_NWRITE))
    else $error("lanes driven without a read strobe");
  a_oe_serial_quiet: assert property (I2C_ACTIVE && $past(I2C_ACTIVE) |-> HOST_DATA_LANES_OE_N)
    else $error("lanes driven in serial mode");
  a_oe_pd_quiet: assert property (POWERDOWN && $past(POWERDOWN) |-> HOST_DATA_LANES_OE_N)
    else $error("lanes driven in power-down");
  a_pd_follows_pin: assert property (1'b1 |=> POWERDOWN == $past(POWERDOWN_IN))
    else $error("power-down output wrong");
  a_osc_follows_pin: assert property (1'b1 |=> USE_INT_OSC == $past(OSC_PIN_HIGH))
    else $error("oscillator select wrong");
  a_subaddr_latch: assert property (I2C_ACTIVE |=> I2C_SUBADDR_BIT == $past(HOST_DATA_LANES_IN[3]))
    else $error("sub-address bit wrong");
  a_cmd_hold: assert property (CMD_VALID && !CMD_READY |=> CMD_VALID && $stable(CMD_DATA))
    else $error("command dropped while stalled");
  a_busy_on_cmd: assert property ($rose(CMD_VALID) |-> ##[0:1] BUSY)
    else $error("busy missing for a command");
endmodule : lcd_host_port_checker
bind lcd_host_port lcd_host_port_checker i_lcd_host_port_checker (
  .CLK(CLK), .RESET(RESET), .STROBE(STROBE), .READ_NWRITE(READ_NWRITE),
  .I2C_ACTIVE(I2C_ACTIVE), .OSC_PIN_HIGH(OSC_PIN_HIGH), .POWERDOWN_IN(POWERDOWN_IN),
  .HOST_DATA_LANES_IN(HOST_DATA_LANES_IN), .HOST_DATA_LANES_OE_N(HOST_DATA_LANES_OE_N),
  .CMD_DATA(CMD_DATA), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .BUSY(BUSY),
  .I2C_SUBADDR_BIT(I2C_SUBADDR_BIT), .POWERDOWN(POWERDOWN), .USE_INT_OSC(USE_INT_OSC));
`default_nettype wire

// File: sim/lcd_host_model.sv
// Host microcontroller model that drives the parallel LCD bus.
`timescale 1ns/10ps
`default_nettype none
module lcd_host_model (
  input  wire logic       clk,
  input  wire logic       four_bit,
  input  wire logic [7:0] lanes,
  output logic            strobe,
  output logic            sel,
  output logic            rnw,
  output logic      [7:0] drv,
  output logic      [7:0] drv_en
);
  // Idle host keeps the strobe low, which also leaves serial mode undisturbed.
  initial begin
    {strobe, sel, rnw} = 3'h0;
    {drv, drv_en} = 16'h0000;
  end
  // One byte, or two nibble strobes with the high nibble first, changed at falling edges.
  task automatic access(input logic s, input logic r, input logic [7:0] d,
                        output logic [7:0] q);
    for (int k = 0; k < (four_bit ? 2 : 1); k++) begin
      @(negedge clk);
      {sel, rnw, strobe} = {s, r, 1'b1};
      drv = (k == 1) ? {d[3:0], 4'h0} : d;
      drv_en = r ? 8'h00 : {4'hf, {4{!four_bit}}};
      repeat (4) @(negedge clk);
      q = (k == 1) ? {q[7:4], lanes[7:4]} : lanes;
      strobe = 1'b0;
      repeat (2) @(negedge clk);
      drv_en = 8'h00;
    end
  endtask : access
endmodule : lcd_host_model
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the LCD host port with a host model on the lanes.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {logic s; logic r; logic f; logic [7:0] e;} row_type;
  logic       clk, reset, four, i2c, pd, osc, done, ready, sa0, strobe, sel, rnw;
  logic       oe_n, cmd_is, cmd_valid, busy, subaddr, pd_out, int_osc, pop;
  logic [7:0] out, cmd_data, drv, drv_en, q;
  logic [8:0] w, cmd_log [16];
  wire  [7:0] lanes;
  int         failures, tests_run, n, nlog, taken, pops;
  // Select, direction, four-bit mode and the byte written or expected back.
  row_type    rows [8] = '{11'h038, 11'h4a5, 11'h25a, 11'h6c3, 11'h128, 11'h55e, 11'h35a, 11'h7c3};
  // Device under test and the host model sharing the lanes.
  lcd_host_port i_lcd_host_port (
    .CLK(clk), .RESET(reset), .STROBE(strobe), .REG_SELECT(sel), .READ_NWRITE(rnw),
    .HOST_DATA_LANES_IN(lanes), .HOST_DATA_LANES_OUT(out), .HOST_DATA_LANES_OE_N(oe_n),
    .BUS_4BIT(four), .I2C_ACTIVE(i2c), .POWERDOWN_IN(pd), .OSC_PIN_HIGH(osc),
    .ADDR_COUNTER_IN(7'h5a), .READ_DATA_IN(8'hc3), .CORE_DONE(done), .CMD_DATA(cmd_data),
    .CMD_IS_DATA(cmd_is), .CMD_VALID(cmd_valid), .CMD_READY(ready), .READ_DATA_POP(pop),
    .BUSY(busy), .I2C_SUBADDR_BIT(subaddr), .POWERDOWN(pd_out), .USE_INT_OSC(int_osc));
  lcd_host_model i_lcd_host_model (.clk(clk), .four_bit(four), .lanes(lanes),
    .strobe(strobe), .sel(sel), .rnw(rnw), .drv(drv), .drv_en(drv_en));
  // Released lanes float to their pull-ups; lane three carries the address strap.
  assign lanes = !oe_n ? out : (drv & drv_en) | (~drv_en & {4'hf, sa0, 3'h7});
  always #25 clk = ~clk;
  // Logs the first 16 command words handed over to the core, and counts data read pops.
  always @(posedge clk) begin
    if (cmd_valid === 1'b1 && ready === 1'b1 && nlog < 16) begin
      cmd_log[nlog] <= {cmd_is, cmd_data};
      nlog <= nlog + 1;
    end
    if (pop === 1'b1) begin
      pops <= pops + 1;
    end
  end
  // Counts a comparison and reports a mismatch at once.
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // Waits for a command word (x if none), optionally ends the core job, then waits for idle.
  task automatic take(input logic pulse, output logic [8:0] c);
    for (n = 0; nlog <= taken && n < 20; n++) @(negedge clk);
    c = (nlog > taken) ? cmd_log[taken] : 9'h0xx;
    if (nlog > taken) begin
      taken++;
    end
    done = pulse;
    @(negedge clk);
    done = 1'b0;
    for (n = 0; busy !== 1'b0 && n < (pulse ? 8 : 60); n++) @(negedge clk);
    check({8'h00, busy}, 9'h000);
  endtask : take
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // Table of plain accesses, then refusal, stall, mode and reset cases.
  initial begin
    {clk, four, i2c, pd, done} = 5'h00;
    {reset, osc, ready, sa0} = 4'hf;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 8; i++) begin
      four = rows[i].f;
      i_lcd_host_model.access(rows[i].s, rows[i].r, rows[i].e, q);
      if (rows[i].r) begin
        check({1'b0, q}, {1'b0, rows[i].e});
      end else begin
        take(1'b1, w);
        check(w, {rows[i].s, rows[i].e});
      end
    end
    check(9'(pops), 9'h002);
    four = 1'b0;
    i_lcd_host_model.access(1'b0, 1'b0, 8'h01, q);
    for (n = 0; nlog <= taken && n < 20; n++) @(negedge clk);
    check(cmd_log[taken], 9'h001);
    taken++;
    i_lcd_host_model.access(1'b0, 1'b1, 8'h00, q);
    check({1'b0, q}, 9'h0da);
    i_lcd_host_model.access(1'b0, 1'b0, 8'h02, q);
    take(1'b0, w);
    check(w, 9'h0xx);
    check({8'h00, busy}, 9'h000);
    ready = 1'b0;
    for (int k = 0; k < 8; k++) i_lcd_host_model.access(1'b1, 1'b0, 8'h10 + 8'(k), q);
    ready = 1'b1;
    for (n = 0; cmd_valid !== 1'b1 && n < 20; n++) @(negedge clk);
    ready = 1'b0;
    repeat (2) @(negedge clk);
    check({cmd_is, cmd_data}, 9'h110);
    check({8'h00, cmd_valid}, 9'h001);
    ready = 1'b1;
    for (int k = 0; k < 8; k++) begin
      take(1'b0, w);
      check(w, {1'b1, 8'h10 + 8'(k)});
    end
    pd = 1'b1;
    i_lcd_host_model.access(1'b1, 1'b0, 8'h77, q);
    take(1'b0, w);
    check(w, 9'h0xx);
    check({8'h00, pd_out}, 9'h001);
    {pd, i2c, sa0} = 3'h2;
    repeat (2) @(negedge clk);
    check({8'h00, subaddr}, 9'h000);
    sa0 = 1'b1;
    repeat (2) @(negedge clk);
    check({8'h00, subaddr}, 9'h001);
    {i2c, osc} = 2'h0;
    repeat (2) @(negedge clk);
    check({8'h00, int_osc}, 9'h000);
    {reset, osc} = 2'h3;
    repeat (2) @(negedge clk);
    check({3'h0, oe_n, busy, cmd_valid, pd_out, int_osc, subaddr}, 9'h022);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    check({3'h0, oe_n, busy, cmd_valid, pd_out, int_osc, subaddr}, 9'h022);
    i_lcd_host_model.access(1'b1, 1'b0, 8'h3c, q);
    take(1'b1, w);
    check(w, 9'h13c);
    give_verdict;
  end
  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    give_verdict;
  end
endmodule : testbench
`default_nettype wire
